// [rtl/apec_pkg.sv]
/*
 * Package for the ambient phase correction and emitter configuration bank:
 * register map, field layouts, reset values, decode helpers.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one register per word.
 */
package apec_pkg;

   // register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_COEF = 8'hB4;
   localparam logic [7:0] IDX_SCALE = 8'hB5;
   localparam logic [7:0] IDX_KNEE = 8'hB8;
   localparam logic [7:0] IDX_EMIT = 8'hB9;
   localparam logic [7:0] IDX_STAT = 8'hBA;
   localparam logic [9:0] ADR_COEF = {IDX_COEF, 2'b00};
   localparam logic [9:0] ADR_SCALE = {IDX_SCALE, 2'b00};
   localparam logic [9:0] ADR_KNEE = {IDX_KNEE, 2'b00};
   localparam logic [9:0] ADR_EMIT = {IDX_EMIT, 2'b00};
   localparam logic [9:0] ADR_STAT = {IDX_STAT, 2'b00};

   localparam logic [23:0] COEF_RST = 24'h000000;
   localparam logic [2:0] SCALE_RST = 3'h0;
   localparam logic [23:0] KNEE_RST = 24'h07FDFF;
   localparam logic [23:0] EMIT_RST = 24'h0001FF;
   // reserved bits 23:21 of the knee register never store a one
   localparam logic [23:0] KNEE_WR_MASK = 24'h1FFFFF;
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_CNT_LSB = 8;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // drive scaling per step code, in microamps
   localparam logic [12:0] STEP_UA_0 = 13'h15E0;
   localparam logic [12:0] STEP_UA_1 = 13'h1068;
   localparam logic [12:0] STEP_UA_2 = 13'h0AF0;
   localparam logic [12:0] STEP_UA_3 = 13'h0578;

   typedef struct packed {
      logic [2:0] resv;
      logic dealias_sel;
      logic [9:0] knee_second;
      logic [9:0] knee_first;
   } apec_knee_t;

   typedef struct packed {
      logic [2:0] step_hi;
      logic [2:0] step_lo;
      logic [1:0] sel_ch2;
      logic [1:0] sel_ch1;
      logic [1:0] sel_ch0;
      logic reroute2;
      logic reroute1;
      logic [9:0] knee_third;
   } apec_emit_t;

   typedef struct packed {
      logic [7:0] coef_three;
      logic [7:0] coef_two;
      logic [7:0] coef_one;
   } apec_coef_t;

   typedef enum logic [1:0] {SRC_DAC_POS, SRC_DAC_NEG, SRC_REF_POS, SRC_REF_NEG} apec_src_t;

   typedef struct packed {
      apec_src_t pos;
      apec_src_t neg;
   } apec_pair_t;

   function automatic logic [23:0] apec_merge(input logic [23:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [23:0] r;
      r = old;
      for (int i = 0; i < 3; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : apec_merge

   // codes above 3 are not valid; they yield no drive
   function automatic logic [12:0] apec_step_ua(input logic [2:0] code);
      case (code)
         3'h0: return STEP_UA_0;
         3'h1: return STEP_UA_1;
         3'h2: return STEP_UA_2;
         3'h3: return STEP_UA_3;
         default: return 13'h0000;
      endcase
   endfunction : apec_step_ua

   function automatic apec_pair_t apec_amb_decode(input logic [1:0] code);
      case (code)
         2'h0: return '{pos: SRC_DAC_POS, neg: SRC_DAC_NEG};
         2'h1: return '{pos: SRC_DAC_POS, neg: SRC_REF_POS};
         2'h2: return '{pos: SRC_DAC_NEG, neg: SRC_DAC_POS};
         default: return '{pos: SRC_DAC_NEG, neg: SRC_REF_NEG};
      endcase
   endfunction : apec_amb_decode

endpackage : apec_pkg

// [rtl/apec_pwl.sv]
/*
 * Piecewise-linear ambient phase correction: three slopes between knees,
 * result shifted right by the scaling factor, one cycle of latency.
 * Assumes configuration inputs are held stable during a frame.
 */
`timescale 1ns/1ns
module apec_pwl import apec_pkg::*; #(
   parameter int AMB_W = 10,
   parameter int CORR_W = 20
) (
   input wire logic sys_clk, // system clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic amb_valid, // ambient sample strobe
   input wire logic [AMB_W-1:0] amb, // ambient sample
   input wire logic [AMB_W-1:0] knee_first, // first knee
   input wire logic [AMB_W-1:0] knee_second, // second knee
   input wire logic [AMB_W-1:0] knee_third, // third knee
   input wire apec_coef_t coef, // segment slopes
   input wire logic [2:0] scale, // right shift of the sum
   output logic [CORR_W-1:0] corr, // correction value
   output logic corr_valid // correction strobe
);

   logic [CORR_W-1:0] corr_d, corr_q;
   logic valid_d, valid_q;

   // part of a between lo and hi; zero when the knees are out of order
   function automatic logic [AMB_W-1:0] seg_len(input logic [AMB_W-1:0] a, input logic [AMB_W-1:0] lo,
                                                 input logic [AMB_W-1:0] hi);
      if (a <= lo || hi <= lo) begin
         return '0;
      end
      return ((a < hi) ? a : hi) - lo;
   endfunction : seg_len

   always_comb begin
      logic [CORR_W-1:0] sum;
      sum = '0;
      // widen both factors first, a self-sized 8 x 10 product would keep only 10 bits
      sum = CORR_W'(coef.coef_one) * CORR_W'(seg_len(amb, knee_first, knee_second))
          + CORR_W'(coef.coef_two) * CORR_W'(seg_len(amb, knee_second, knee_third))
          + CORR_W'(coef.coef_three) * CORR_W'(seg_len(amb, knee_third, {AMB_W{1'b1}}));
      valid_d = amb_valid;
      corr_d = amb_valid ? (sum >> scale) : corr_q;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         corr_q <= '0;
         valid_q <= 1'b0;
      end else begin
         corr_q <= corr_d;
         valid_q <= valid_d;
      end
   end

   assign corr = corr_q;
   assign corr_valid = valid_q;

   property p_pwl_flat;
      @(posedge sys_clk) disable iff (!rst_n)
      amb_valid && amb <= knee_first && knee_first <= knee_second && knee_second <= knee_third
      |=> corr_valid && corr == '0;
   endproperty
   a_pwl_flat: assert property (p_pwl_flat) else $error("correction not zero below first knee");

   property p_pwl_scaled;
      @(posedge sys_clk) disable iff (!rst_n)
      amb_valid && amb > knee_first && amb < knee_second && amb <= knee_third
      |=> corr == CORR_W'((CORR_W'($past(coef.coef_one)) * CORR_W'($past(amb) - $past(knee_first)))
                          >> $past(scale));
   endproperty
   a_pwl_scaled: assert property (p_pwl_scaled) else $error("first segment not scaled");

endmodule : apec_pwl

// [rtl/apec_cfg.sv]
/*
 * Ambient phase correction and emitter configuration register bank with
 * per-frame shadowing, phase output select, emitter steering and ambient
 * ADC input selection.
 * Assumes an Avalon-MM master on sys_clk and a measurement pipeline on the
 * same clock that marks frames with frame_start and frame_end pulses.
 */
`timescale 1ns/1ns
module apec_cfg import apec_pkg::*; #(
   parameter int PHASE_W = 16,
   parameter int AMB_W = 10,
   parameter int CORR_W = 20
) (
   input wire logic sys_clk, // system clock, 100 MHz
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [9:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic [1:0] avs_response, // okay or slave error
   output logic avs_waitrequest, // stall
   input wire logic frame_start, // frame begins, pulse
   input wire logic frame_end, // frame ends, pulse
   input wire logic [1:0] emit_ch_sel, // active emitter channel 0..2
   input wire logic emit_drive_high, // high DAC current phase
   input wire logic phase_valid, // phase sample strobe
   input wire logic [PHASE_W-1:0] phase_in, // ordinary phase
   input wire logic [PHASE_W-1:0] dealiased_phase_in, // de-aliased phase
   input wire logic amb_valid, // ambient sample strobe
   input wire logic [AMB_W-1:0] ambient_in, // ambient sample
   output logic [PHASE_W-1:0] phase_result_output, // selected phase
   output logic phase_result_valid, // phase strobe
   output logic [2:0] emitter_drive_en, // one-hot emitter pad enable
   output logic [12:0] drive_current_ua, // channel 2 drive step in uA
   output apec_pair_t ambient_src, // ambient ADC input pair
   output logic [CORR_W-1:0] ambient_correction, // phase correction
   output logic ambient_correction_valid // correction strobe
);

   typedef enum logic {FR_IDLE, FR_RUN} apec_state_t;

   // bus handshake
   logic ack_d, ack_q;
   logic [31:0] rdata_d, rdata_q;
   logic [1:0] resp_d, resp_q;
   logic req, commit;

   // live registers
   apec_knee_t knee_d, knee_q;
   apec_emit_t emit_d, emit_q;
   apec_coef_t coef_d, coef_q;
   logic [2:0] scale_d, scale_q;

   // frame shadows
   apec_state_t state_d, state_q;
   apec_knee_t knee_sh_d, knee_sh_q;
   apec_emit_t emit_sh_d, emit_sh_q;
   apec_coef_t coef_sh_d, coef_sh_q;
   logic [2:0] scale_sh_d, scale_sh_q;
   logic [7:0] frame_cnt_d, frame_cnt_q;

   // outputs
   logic [PHASE_W-1:0] phase_d, phase_q;
   logic phase_vld_d, phase_vld_q;
   logic [2:0] drive_en_d, drive_en_q;
   logic [12:0] drive_ua_d, drive_ua_q;
   apec_pair_t src_d, src_q;

   // every access stalls one cycle so read data comes from a flop
   assign req = avs_read | avs_write;
   assign commit = req & ack_q;
   assign avs_waitrequest = req & ~ack_q;

   always_comb begin
      ack_d = req & ~ack_q;
      resp_d = RESP_OKAY;
      rdata_d = 32'h00000000;
      case (avs_address)
         ADR_COEF: rdata_d = {8'h00, coef_q};
         ADR_SCALE: rdata_d = {29'h00000000, scale_q};
         ADR_KNEE: rdata_d = {8'h00, 3'h0, knee_q.dealias_sel, knee_q.knee_second, knee_q.knee_first};
         ADR_EMIT: rdata_d = {8'h00, emit_q};
         ADR_STAT: begin
            rdata_d[STAT_RUN_BIT] = (state_q == FR_RUN);
            rdata_d[STAT_CNT_LSB +: 8] = frame_cnt_q;
         end
         default: resp_d = RESP_SLVERR;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
         resp_q <= RESP_OKAY;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         resp_q <= resp_d;
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_response = resp_q;

   // register writes land on the edge where waitrequest is low
   always_comb begin
      knee_d = knee_q;
      emit_d = emit_q;
      coef_d = coef_q;
      scale_d = scale_q;
      if (commit && avs_write) begin
         case (avs_address)
            ADR_COEF: coef_d = apec_coef_t'(apec_merge(coef_q, avs_writedata, avs_byteenable));
            ADR_SCALE: begin
               if (avs_byteenable[0]) begin
                  scale_d = avs_writedata[2:0];
               end
            end
            ADR_KNEE: knee_d = apec_knee_t'(apec_merge(knee_q, avs_writedata, avs_byteenable) & KNEE_WR_MASK);
            ADR_EMIT: emit_d = apec_emit_t'(apec_merge(emit_q, avs_writedata, avs_byteenable));
            default: knee_d = knee_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         knee_q <= apec_knee_t'(KNEE_RST);
         emit_q <= apec_emit_t'(EMIT_RST);
         coef_q <= apec_coef_t'(COEF_RST);
         scale_q <= SCALE_RST;
      end else begin
         knee_q <= knee_d;
         emit_q <= emit_d;
         coef_q <= coef_d;
         scale_q <= scale_d;
      end
   end

   // shadows load only at frame start; a write mid-frame waits for the next one
   always_comb begin
      state_d = state_q;
      knee_sh_d = knee_sh_q;
      emit_sh_d = emit_sh_q;
      coef_sh_d = coef_sh_q;
      scale_sh_d = scale_sh_q;
      frame_cnt_d = frame_cnt_q;
      case (state_q)
         FR_IDLE: begin
            if (frame_start) begin
               state_d = FR_RUN;
            end
         end
         FR_RUN: begin
            if (frame_start) begin
               state_d = FR_RUN;
            end else if (frame_end) begin
               state_d = FR_IDLE;
            end
         end
         default: state_d = FR_IDLE;
      endcase
      if (frame_start) begin
         knee_sh_d = knee_q;
         emit_sh_d = emit_q;
         coef_sh_d = coef_q;
         scale_sh_d = scale_q;
         frame_cnt_d = frame_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q <= FR_IDLE;
         knee_sh_q <= apec_knee_t'(KNEE_RST);
         emit_sh_q <= apec_emit_t'(EMIT_RST);
         coef_sh_q <= apec_coef_t'(COEF_RST);
         scale_sh_q <= SCALE_RST;
         frame_cnt_q <= 8'h00;
      end else begin
         state_q <= state_d;
         knee_sh_q <= knee_sh_d;
         emit_sh_q <= emit_sh_d;
         coef_sh_q <= coef_sh_d;
         scale_sh_q <= scale_sh_d;
         frame_cnt_q <= frame_cnt_d;
      end
   end

   // steering works from the frame's shadow copy; emitter is dark between frames
   always_comb begin
      phase_vld_d = phase_valid;
      phase_d = phase_q;
      if (phase_valid) begin
         phase_d = knee_sh_q.dealias_sel ? dealiased_phase_in : phase_in;
      end
      drive_en_d = 3'h0;
      drive_ua_d = 13'h0000;
      src_d = apec_amb_decode(emit_sh_q.sel_ch0);
      case (emit_ch_sel)
         2'h1: begin
            src_d = apec_amb_decode(emit_sh_q.sel_ch1);
            drive_en_d = emit_sh_q.reroute1 ? 3'h1 : 3'h2;
         end
         2'h2: begin
            src_d = apec_amb_decode(emit_sh_q.sel_ch2);
            drive_en_d = emit_sh_q.reroute2 ? 3'h1 : 3'h4;
            drive_ua_d = emit_drive_high ? apec_step_ua(emit_sh_q.step_hi)
                                         : apec_step_ua(emit_sh_q.step_lo);
         end
         2'h0: drive_en_d = 3'h1;
         default: drive_en_d = 3'h0;
      endcase
      if (state_q != FR_RUN) begin
         drive_en_d = 3'h0;
         drive_ua_d = 13'h0000;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         phase_q <= '0;
         phase_vld_q <= 1'b0;
         drive_en_q <= 3'h0;
         drive_ua_q <= 13'h0000;
         src_q <= '{pos: SRC_DAC_POS, neg: SRC_DAC_NEG};
      end else begin
         phase_q <= phase_d;
         phase_vld_q <= phase_vld_d;
         drive_en_q <= drive_en_d;
         drive_ua_q <= drive_ua_d;
         src_q <= src_d;
      end
   end

   assign phase_result_output = phase_q;
   assign phase_result_valid = phase_vld_q;
   assign emitter_drive_en = drive_en_q;
   assign drive_current_ua = drive_ua_q;
   assign ambient_src = src_q;

   apec_pwl #(.AMB_W(AMB_W), .CORR_W(CORR_W)) u_pwl (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .amb_valid(amb_valid),
      .amb(ambient_in),
      .knee_first(knee_sh_q.knee_first),
      .knee_second(knee_sh_q.knee_second),
      .knee_third(emit_sh_q.knee_third),
      .coef(coef_sh_q),
      .scale(scale_sh_q),
      .corr(ambient_correction),
      .corr_valid(ambient_correction_valid)
   );

   sequence s_rd_knee;
      avs_read && !avs_waitrequest && avs_address == ADR_KNEE;
   endsequence

   sequence s_run_ch(logic [1:0] ch);
      state_q == FR_RUN && emit_ch_sel == ch;
   endsequence

   property p_phase_sel;
      @(posedge sys_clk) disable iff (!rst_n)
      phase_valid |=> phase_result_valid
         && phase_result_output == ($past(knee_sh_q.dealias_sel) ? $past(dealiased_phase_in) : $past(phase_in));
   endproperty
   a_phase_sel: assert property (p_phase_sel) else $error("phase output source wrong");

   property p_resv_zero;
      @(posedge sys_clk) disable iff (!rst_n)
      s_rd_knee |-> avs_readdata[23:21] == 3'h0;
   endproperty
   a_resv_zero: assert property (p_resv_zero) else $error("reserved knee bits read nonzero");

   property p_knee_first_rst;
      @(posedge sys_clk) !rst_n |=> knee_q.knee_first == 10'h1FF;
   endproperty
   a_knee_first_rst: assert property (p_knee_first_rst) else $error("first knee reset wrong");

   property p_knee_second_rst;
      @(posedge sys_clk) !rst_n |=> knee_q.knee_second == 10'h1FF && !knee_q.dealias_sel;
   endproperty
   a_knee_second_rst: assert property (p_knee_second_rst) else $error("second knee reset wrong");

   property p_knee_third_rst;
      @(posedge sys_clk) !rst_n |=> emit_q == 24'h0001FF;
   endproperty
   a_knee_third_rst: assert property (p_knee_third_rst) else $error("third knee reset wrong");

   property p_drive_hi;
      @(posedge sys_clk) disable iff (!rst_n)
      s_run_ch(2'h2) and emit_drive_high && emit_sh_q.step_hi == 3'h0 |=> drive_current_ua == 13'd5600;
   endproperty
   a_drive_hi: assert property (p_drive_hi) else $error("high step 0 not 5.6 mA");

   property p_drive_lo;
      @(posedge sys_clk) disable iff (!rst_n)
      s_run_ch(2'h2) and !emit_drive_high && emit_sh_q.step_lo == 3'h3 |=> drive_current_ua == 13'd1400;
   endproperty
   a_drive_lo: assert property (p_drive_lo) else $error("low step 3 not 1.4 mA");

   property p_amb_ch2;
      @(posedge sys_clk) disable iff (!rst_n)
      emit_ch_sel == 2'h2 && emit_sh_q.sel_ch2 == 2'h1 |=> ambient_src.pos == SRC_DAC_POS
         && ambient_src.neg == SRC_REF_POS;
   endproperty
   a_amb_ch2: assert property (p_amb_ch2) else $error("channel 2 ambient pair wrong");

   property p_amb_ch1;
      @(posedge sys_clk) disable iff (!rst_n)
      emit_ch_sel == 2'h1 && emit_sh_q.sel_ch1 == 2'h2 |=> ambient_src.pos == SRC_DAC_NEG
         && ambient_src.neg == SRC_DAC_POS;
   endproperty
   a_amb_ch1: assert property (p_amb_ch1) else $error("channel 1 ambient pair wrong");

   property p_amb_ch0;
      @(posedge sys_clk) disable iff (!rst_n)
      emit_ch_sel == 2'h0 && emit_sh_q.sel_ch0 == 2'h3 |=> ambient_src.pos == SRC_DAC_NEG
         && ambient_src.neg == SRC_REF_NEG;
   endproperty
   a_amb_ch0: assert property (p_amb_ch0) else $error("channel 0 ambient pair wrong");

   property p_reroute2;
      @(posedge sys_clk) disable iff (!rst_n)
      s_run_ch(2'h2) |=> emitter_drive_en == ($past(emit_sh_q.reroute2) ? 3'h1 : 3'h4);
   endproperty
   a_reroute2: assert property (p_reroute2) else $error("channel 2 steering wrong");

   property p_reroute1;
      @(posedge sys_clk) disable iff (!rst_n)
      s_run_ch(2'h1) |=> emitter_drive_en == ($past(emit_sh_q.reroute1) ? 3'h1 : 3'h2);
   endproperty
   a_reroute1: assert property (p_reroute1) else $error("channel 1 steering wrong");

   property p_shadow_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      !frame_start |=> $stable(knee_sh_q) && $stable(emit_sh_q) && $stable(coef_sh_q) && $stable(scale_sh_q);
   endproperty
   a_shadow_hold: assert property (p_shadow_hold) else $error("settings changed inside a frame");

endmodule : apec_cfg

// [verif/apec_cfg_test.sv]
/*
 * Self-checking bench for apec_cfg: register map and reset values,
 * phase output select, frame shadowing, emitter steering, ambient input
 * select and the ambient correction.
 * Assumes the one-wait-state Avalon-MM slave and 100 MHz sys_clk.
 */
`timescale 1ns/1ns
module apec_cfg_test import apec_pkg::*;;
   typedef struct {logic wr; logic [9:0] a; logic [31:0] d; logic [31:0] ex; logic [1:0] er;} apec_row_t;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] avs_address = 10'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic [1:0] avs_response;
   logic avs_waitrequest;
   logic frame_start = 1'b0;
   logic frame_end = 1'b0;
   logic [1:0] emit_ch_sel = 2'h3;
   logic emit_drive_high = 1'b0;
   logic phase_valid = 1'b0;
   logic [15:0] phase_in = 16'h0;
   logic [15:0] dealiased_phase_in = 16'h0;
   logic amb_valid = 1'b0;
   logic [9:0] ambient_in = 10'h000;
   logic [15:0] phase_result_output;
   logic phase_result_valid;
   logic [2:0] emitter_drive_en;
   logic [12:0] drive_current_ua;
   apec_pair_t ambient_src;
   logic [19:0] ambient_correction;
   logic ambient_correction_valid;
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic [1:0] rs;
   // pair codes as {pos,neg} and channel 2 drive steps, in code order
   logic [3:0] src_t [4] = '{4'h1, 4'h2, 4'h4, 4'h7};
   logic [12:0] ua_t [4] = '{13'h15E0, 13'h1068, 13'h0AF0, 13'h0578};
   apec_row_t rows [14] = '{
      '{1'b0, ADR_KNEE, 32'h0, 32'h0007FDFF, 2'h0}, '{1'b0, ADR_EMIT, 32'h0, 32'h000001FF, 2'h0},
      '{1'b1, ADR_KNEE, 32'hFFFFFFFF, 32'h0, 2'h0}, '{1'b0, ADR_KNEE, 32'h0, 32'h001FFFFF, 2'h0},
      '{1'b1, ADR_EMIT, 32'hFFFFFFFF, 32'h0, 2'h0}, '{1'b0, ADR_EMIT, 32'h0, 32'h00FFFFFF, 2'h0},
      '{1'b1, 10'h000, 32'h5, 32'h0, 2'h2}, '{1'b0, 10'h000, 32'h0, 32'h0, 2'h2},
      '{1'b0, ADR_COEF, 32'h0, 32'h0, 2'h0},
      '{1'b1, ADR_SCALE, 32'hFFFFFFFF, 32'h0, 2'h0}, '{1'b0, ADR_SCALE, 32'h0, 32'h00000007, 2'h0},
      '{1'b1, ADR_COEF, 32'hFFFFFFFF, 32'h0, 2'h0}, '{1'b0, ADR_COEF, 32'h0, 32'h00FFFFFF, 2'h0},
      '{1'b0, ADR_STAT, 32'h0, 32'h0, 2'h0}};

   apec_cfg apec_cfg_inst (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_response, .avs_waitrequest, .frame_start, .frame_end,
      .emit_ch_sel, .emit_drive_high, .phase_valid, .phase_in, .dealiased_phase_in, .amb_valid,
      .ambient_in, .phase_result_output, .phase_result_valid, .emitter_drive_en, .drive_current_ua,
      .ambient_src, .ambient_correction, .ambient_correction_valid);

   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic conclude;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_count++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] ex);
      compares++;
      if (got !== ex) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, ex);
      end
   endtask : chk

   // holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge sys_clk);
      end
      rd = avs_readdata;
      rs = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask : bus

   task automatic fs;
      frame_start <= 1'b1;
      @(posedge sys_clk);
      frame_start <= 1'b0;
   endtask : fs

   task automatic ph(input logic [15:0] o, input logic [15:0] dd, input logic [15:0] ex);
      phase_in <= o;
      dealiased_phase_in <= dd;
      phase_valid <= 1'b1;
      @(posedge sys_clk);
      phase_valid <= 1'b0;
      @(negedge sys_clk);
      chk(phase_result_valid, 1);
      chk(phase_result_output, ex);
      @(posedge sys_clk);
   endtask : ph

   task automatic am(input logic [9:0] a, input logic [19:0] ex);
      ambient_in <= a;
      amb_valid <= 1'b1;
      @(posedge sys_clk);
      amb_valid <= 1'b0;
      @(negedge sys_clk);
      chk(ambient_correction_valid, 1);
      chk(ambient_correction, ex);
      @(posedge sys_clk);
   endtask : am

   initial begin
      logic [1:0] c;
      logic [1:0] s [3];
      logic [2:0] hi;
      logic [2:0] lo;
      repeat (7) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(avs_waitrequest, 0);
      chk({emitter_drive_en, phase_result_valid, drive_current_ua}, 0);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      $display("reset test done");
      foreach (rows[i]) begin
         bus(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr) chk(rd, rows[i].ex);
         chk(rs, rows[i].er);
      end
      $display("register table done");
      bus(1'b1, ADR_KNEE, 32'h00108010);
      bus(1'b1, ADR_EMIT, 32'h00000030);
      bus(1'b1, ADR_COEF, 32'h00000002);
      bus(1'b1, ADR_SCALE, 32'h00000001);
      ph(16'h1111, 16'h2222, 16'h1111);
      fs();
      ph(16'h1111, 16'h2222, 16'h2222);
      am(10'h018, 20'h00008);
      am(10'h008, 20'h00000);
      bus(1'b1, ADR_KNEE, 32'h0);
      ph(16'h3333, 16'h4444, 16'h4444);
      $display("phase and correction test done");
      for (int i = 0; i < 4; i++) begin
         c = i[1:0];
         hi = {1'b0, c};
         lo = 3'h3 - hi;
         s[2] = c;
         s[1] = c + 2'h1;
         s[0] = c + 2'h2;
         bus(1'b1, ADR_EMIT, {8'h00, hi, lo, s[2], s[1], s[0], c[0], c[1], 10'h1FF});
         fs();
         for (int ch = 0; ch < 3; ch++) begin
            for (int h = 0; h < 2; h++) begin
               emit_ch_sel <= ch[1:0];
               emit_drive_high <= h[0];
               @(posedge sys_clk);
               @(negedge sys_clk);
               chk(ambient_src, src_t[s[ch]]);
               chk(drive_current_ua, (ch == 2) ? ua_t[h ? hi[1:0] : lo[1:0]] : 13'h0);
               chk(emitter_drive_en, (ch == 0) ? 3'h1 : (ch == 1) ? (c[1] ? 3'h1 : 3'h2) : (c[0] ? 3'h1 : 3'h4));
               @(posedge sys_clk);
            end
         end
      end
      frame_end <= 1'b1;
      emit_ch_sel <= 2'h0;
      @(posedge sys_clk);
      frame_end <= 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(emitter_drive_en, 0);
      @(posedge sys_clk);
      bus(1'b0, ADR_STAT, 32'h0);
      chk(rd, 32'h00000500);
      $display("emitter test done");
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      bus(1'b0, ADR_KNEE, 32'h0);
      chk(rd, 32'h0007FDFF);
      $display("second reset test done");
      conclude();
   end
endmodule : apec_cfg_test
